// ===== rat_pkg.sv
package rat_pkg;

   // ==========================================================
   // Operation codes
   typedef enum logic [2:0] {
      float_divide_op    = 3'h0,
      float_root_op      = 3'h1,
      float_magnitude_op = 3'h2,
      float_negate_op    = 3'h3,
      trig_ordinate_op   = 3'h4,
      trig_abscissa_op   = 3'h5
   } rat_op_t;

   // ==========================================================
   // Operand and request layout
   typedef struct packed {
      logic [15:0] hi_word;
      logic [15:0] lo_word;
   } rat_real_t;

   typedef struct packed {
      rat_op_t   op;
      rat_real_t first_source_operand;
      rat_real_t second_source_operand;
   } rat_req_t;

   typedef struct packed {
      logic zero_result_flag;
      logic range_overflow_flag;
      logic div_zero_err;
      logic operand_err;
   } rat_stat_t;

   // ==========================================================
   // Constants
   localparam int          RAT_PROG_STEPS_SINGLE = 7;
   localparam int          RAT_PROG_STEPS_DUAL   = 10;
   localparam logic [31:0] RAT_MAX_MAG           = 32'h7EFFFFFF;
   localparam logic [31:0] RAT_RESET_RESULT      = 32'h00000000;
   localparam logic [31:0] RAT_ONE               = 32'h3F800000;
   localparam logic [31:0] RAT_HALF_PI           = 32'h3FC90FDB;
   localparam logic [31:0] RAT_PI                = 32'h40490FDB;
   localparam logic [31:0] RAT_TWO_PI            = 32'h40C90FDB;
   localparam logic [31:0] RAT_INV_TWO_PI        = 32'h3E22F983;
   localparam logic [4:0]  RAT_DIV_ITER          = 5'h19;
   localparam logic [4:0]  RAT_SQRT_ITER         = 5'h19;
   localparam logic [3:0]  RAT_TRIG_TERMS        = 4'h6;

endpackage : rat_pkg

// ===== rat_fmul.sv
`timescale 1ns/1ps
// Combinational single-precision multiply, truncating, flush to zero
module rat_fmul (
   // Operands
   input  logic [31:0] a,
   input  logic [31:0] b,
   // Product
   output logic [31:0] p
);
   logic [47:0] prod;
   logic [9:0]  exp_s;
   logic [23:0] man;
   logic [9:0]  e_fix;

   always_comb begin
      prod  = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      exp_s = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'h07F;
      if (prod[47]) begin
         man   = prod[47:24];
         e_fix = exp_s + 10'h001;
      end else begin
         man   = prod[46:23];
         e_fix = exp_s;
      end
      if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e_fix[9] || e_fix == 10'h000) begin
         p = 32'h00000000;
      end else if (e_fix[8] || e_fix[7:0] == 8'hFF) begin
         p = {a[31] ^ b[31], 8'hFF, 23'h000000};
      end else begin
         p = {a[31] ^ b[31], e_fix[7:0], man[22:0]};
      end
   end
endmodule : rat_fmul

// ===== rat_unit.sv
`timescale 1ns/1ps
module rat_unit (
   // Clock and reset
   input  logic              clk,
   input  logic              rst,
   // Request from the sequencer
   input  logic              req_valid,
   output logic              req_ready,
   input  rat_pkg::rat_req_t req,
   // Destination operand
   output logic              dst_we,
   output rat_pkg::rat_real_t dst,
   // Status
   output rat_pkg::rat_stat_t stat,
   output logic              done,
   output logic [3:0]        prog_steps
);
   typedef enum logic [2:0] {ST_IDLE, ST_DIV, ST_SQRT, ST_RED, ST_PREP, ST_TRIG, ST_DONE} rat_state_t;

   rat_state_t  state_r;
   rat_pkg::rat_op_t op_r;
   logic [31:0] a_r, b_r;
   logic [31:0] res_r;
   logic [4:0]  cnt_r;
   logic [25:0] rem_r, quo_r;
   logic [9:0]  exp_r;
   logic [31:0] x2_r, term_r, sum_r;
   logic [31:0] mul_a, mul_b, mul_p;
   logic        neg_r;
   logic [49:0] rad_r;
   logic [25:0] root_r;
   logic [27:0] srem_r;
   logic signed [31:0] ang_r;
   logic [31:0] ang_f, coef_a, coef_b, coef_p, term_nxt, inv_k, wr_val, trig_val;
   logic [9:0]  e_q;
   logic [22:0] m_q;
   logic        wr_ovf, wr_zero;

   // Angle constants in Q4.27
   localparam logic signed [31:0] FIX_PI      = 32'h1921FB54;
   localparam logic signed [31:0] FIX_HALF_PI = 32'h0C90FDAA;
   localparam logic signed [31:0] FIX_TWO_PI  = 32'h3243F6A9;
   localparam logic signed [31:0] FIX_ONE     = 32'h08000000;

   // Operand words assembled high half first
   logic [31:0] s1, s2;
   assign s1 = {req.first_source_operand.hi_word, req.first_source_operand.lo_word};
   assign s2 = {req.second_source_operand.hi_word, req.second_source_operand.lo_word};

   assign req_ready = (state_r == ST_IDLE);

   // Float to signed Q4.27; angles of magnitude 16 and above read as zero
   function automatic logic [31:0] to_fix(input logic [31:0] f);
      logic [55:0] m;
      m = {32'h00000000, 1'b1, f[22:0]};
      to_fix = 32'h00000000;
      if (f[30:23] >= 8'h67 && f[30:23] <= 8'h82) begin
         m = m << (f[30:23] - 8'h67);
         to_fix = f[31] ? 32'h00000000 - m[51:20] : m[51:20];
      end
   endfunction : to_fix

   // Signed Q4.27 back to float, truncating
   function automatic logic [31:0] fix_to_float(input logic [31:0] v);
      logic [31:0] m;
      logic [7:0]  e;
      m = v[31] ? 32'h00000000 - v : v;
      e = 8'h00;
      fix_to_float = 32'h00000000;
      for (int i = 0; i < 31; i++) begin
         if (m[i]) begin
            e = 8'(i);
         end
      end
      if (m != 32'h00000000) begin
         m = m << (5'h1F - e[4:0]);
         fix_to_float = {v[31], 8'h64 + e, m[30:8]};
      end
   endfunction : fix_to_float

   assign ang_f    = fix_to_float(ang_r);
   assign term_nxt = {~mul_p[31], mul_p[30:0]};

   rat_fmul u_mul (
      .a (mul_a),
      .b (mul_b),
      .p (mul_p)
   );

   rat_fmul u_coef (
      .a (coef_a),
      .b (coef_b),
      .p (coef_p)
   );

   // ==========================================================
   // Series step: next term is term * -x^2 / (k(k+1))
   always_comb begin
      coef_a = x2_r;
      coef_b = inv_k;
      mul_a  = term_r;
      mul_b  = coef_p;
      if (state_r == ST_PREP) begin
         mul_a = ang_f;
         mul_b = ang_f;
      end
   end

   // Reciprocals of k(k+1): cosine 2,12,30,56,90,132; sine 6,20,42,72,110,156
   always_comb begin
      case ({op_r == rat_pkg::trig_ordinate_op, cnt_r[2:0]})
         4'h0:    inv_k = 32'h3F000000;
         4'h1:    inv_k = 32'h3DAAAAAB;
         4'h2:    inv_k = 32'h3D088889;
         4'h3:    inv_k = 32'h3C924925;
         4'h4:    inv_k = 32'h3C360B61;
         4'h5:    inv_k = 32'h3BF83E10;
         4'h8:    inv_k = 32'h3E2AAAAB;
         4'h9:    inv_k = 32'h3D4CCCCD;
         4'hA:    inv_k = 32'h3CC30C31;
         4'hB:    inv_k = 32'h3C638E39;
         4'hC:    inv_k = 32'h3C14F209;
         4'hD:    inv_k = 32'h3BD20D21;
         default: inv_k = 32'h00000000;
      endcase
   end

   // ==========================================================
   // Result written at completion, with its flags
   always_comb begin
      e_q      = quo_r[24] ? exp_r : exp_r - 10'h001;
      m_q      = quo_r[24] ? quo_r[23:1] : quo_r[22:0];
      trig_val = fix_to_float(sum_r);
      if (neg_r && trig_val[30:0] != 31'h0) begin
         trig_val = {~trig_val[31], trig_val[30:0]};
      end
      wr_val = res_r;
      wr_ovf = 1'b0;
      case (op_r)
         rat_pkg::float_divide_op: begin
            if (a_r[30:23] == 8'h00 || e_q[9] || e_q == 10'h000) begin
               wr_val = 32'h00000000;
            end else if (e_q[8] || e_q[7:0] == 8'hFF || (e_q[7:0] == 8'hFE && m_q != 23'h0)) begin
               wr_val = {a_r[31] ^ b_r[31], rat_pkg::RAT_MAX_MAG[30:0]};
               wr_ovf = 1'b1;
            end else begin
               wr_val = {a_r[31] ^ b_r[31], e_q[7:0], m_q};
            end
         end
         rat_pkg::float_root_op: begin
            if (a_r[30:23] == 8'h00) begin
               wr_val = 32'h00000000;
            end else begin
               wr_val = {1'b0, 8'(({2'b00, a_r[30:23]} + 10'h07F) >> 1), root_r[22:0]};
            end
         end
         rat_pkg::trig_ordinate_op, rat_pkg::trig_abscissa_op: begin
            wr_val = trig_val;
         end
         default: begin
            wr_val = res_r;
         end
      endcase
      wr_zero = (wr_val[30:0] == 31'h0) && (op_r != rat_pkg::float_magnitude_op)
                && (op_r != rat_pkg::float_negate_op);
   end

   // ==========================================================
   // Control and arithmetic
   logic [26:0] sub_d;
   logic [27:0] sub_s;
   assign sub_d = {1'b0, rem_r} - {2'b01, b_r[22:0]};
   assign sub_s = srem_r - {root_r, 2'b01};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         op_r    <= rat_pkg::float_divide_op;
         a_r     <= 32'h00000000;
         b_r     <= 32'h00000000;
         res_r   <= rat_pkg::RAT_RESET_RESULT;
         cnt_r   <= 5'h00;
         rem_r   <= 26'h0000000;
         quo_r   <= 26'h0000000;
         exp_r   <= 10'h000;
         x2_r    <= 32'h00000000;
         term_r  <= 32'h00000000;
         sum_r   <= 32'h00000000;
         neg_r   <= 1'b0;
         rad_r   <= 50'h0;
         root_r  <= 26'h0000000;
         srem_r  <= 28'h0000000;
         ang_r   <= 32'sh00000000;
         dst_we  <= 1'b0;
         dst     <= '0;
         stat    <= '0;
         done    <= 1'b0;
      end else begin
         dst_we <= 1'b0;
         done   <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (req_valid) begin
                  op_r <= req.op;
                  a_r  <= s1;
                  b_r  <= s2;
                  stat <= '0;
                  case (req.op)
                     rat_pkg::float_divide_op: begin
                        if (s2[30:0] == 31'h0) begin
                           stat.div_zero_err <= 1'b1;
                           done    <= 1'b1;
                        end else if (s1[30:23] == 8'h00) begin
                           res_r   <= 32'h00000000;
                           state_r <= ST_DONE;
                        end else begin
                           rem_r   <= {3'b001, s1[22:0]};
                           quo_r   <= 26'h0;
                           exp_r   <= {2'b00, s1[30:23]} - {2'b00, s2[30:23]} + 10'h07F;
                           cnt_r   <= rat_pkg::RAT_DIV_ITER;
                           state_r <= ST_DIV;
                        end
                     end
                     rat_pkg::float_root_op: begin
                        if (s1[31] && s1[30:0] != 31'h0) begin
                           stat.operand_err <= 1'b1;
                           done    <= 1'b1;
                        end else if (s1[30:23] == 8'h00) begin
                           res_r   <= 32'h00000000;
                           state_r <= ST_DONE;
                        end else begin
                           rad_r   <= s1[23] ? {2'b01, s1[22:0], 25'h0} : {1'b1, s1[22:0], 26'h0};
                           exp_r   <= {2'b00, s1[30:23]};
                           root_r  <= 26'h0;
                           srem_r  <= 28'h0;
                           cnt_r   <= rat_pkg::RAT_SQRT_ITER;
                           state_r <= ST_SQRT;
                        end
                     end
                     rat_pkg::float_magnitude_op: begin
                        res_r   <= {1'b0, s1[30:0]};
                        state_r <= ST_DONE;
                     end
                     rat_pkg::float_negate_op: begin
                        res_r   <= {~s1[31], s1[30:0]};
                        state_r <= ST_DONE;
                     end
                     default: begin
                        ang_r   <= to_fix(s1);
                        neg_r   <= 1'b0;
                        state_r <= ST_RED;
                     end
                  endcase
               end
            end
            ST_DIV: begin
               if (!sub_d[26]) begin
                  rem_r <= {sub_d[24:0], 1'b0};
                  quo_r <= {quo_r[24:0], 1'b1};
               end else begin
                  rem_r <= {rem_r[24:0], 1'b0};
                  quo_r <= {quo_r[24:0], 1'b0};
               end
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_DONE;
               end
            end
            ST_SQRT: begin
               if (!sub_s[27]) begin
                  srem_r <= {sub_s[25:0], rad_r[49:48]};
                  root_r <= {root_r[24:0], 1'b1};
               end else begin
                  srem_r <= {srem_r[25:0], rad_r[49:48]};
                  root_r <= {root_r[24:0], 1'b0};
               end
               rad_r <= {rad_r[47:0], 2'b00};
               cnt_r <= cnt_r - 5'h01;
               if (cnt_r == 5'h01) begin
                  state_r <= ST_DONE;
               end
            end
            ST_RED: begin
               // Bring the angle into [-pi/2, pi/2]; cosine changes sign when folded
               if (ang_r > FIX_PI) begin
                  ang_r <= ang_r - FIX_TWO_PI;
               end else if (ang_r < -FIX_PI) begin
                  ang_r <= ang_r + FIX_TWO_PI;
               end else begin
                  if (ang_r > FIX_HALF_PI) begin
                     ang_r <= FIX_PI - ang_r;
                     neg_r <= (op_r == rat_pkg::trig_abscissa_op);
                  end else if (ang_r < -FIX_HALF_PI) begin
                     ang_r <= -FIX_PI - ang_r;
                     neg_r <= (op_r == rat_pkg::trig_abscissa_op);
                  end
                  state_r <= ST_PREP;
               end
            end
            ST_PREP: begin
               x2_r    <= mul_p;
               term_r  <= (op_r == rat_pkg::trig_ordinate_op) ? ang_f : rat_pkg::RAT_ONE;
               sum_r   <= (op_r == rat_pkg::trig_ordinate_op) ? ang_r : FIX_ONE;
               cnt_r   <= 5'h00;
               state_r <= ST_TRIG;
            end
            ST_TRIG: begin
               term_r <= term_nxt;
               sum_r  <= sum_r + to_fix(term_nxt);
               cnt_r  <= cnt_r + 5'h01;
               if (cnt_r[3:0] == rat_pkg::RAT_TRIG_TERMS - 4'h1) begin
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               dst                      <= wr_val;
               stat.range_overflow_flag <= wr_ovf;
               stat.zero_result_flag    <= wr_zero;
               dst_we  <= 1'b1;
               done    <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Program length of the instruction in flight
   always_comb begin
      prog_steps = (op_r == rat_pkg::float_divide_op) ? 4'(rat_pkg::RAT_PROG_STEPS_DUAL)
                                                       : 4'(rat_pkg::RAT_PROG_STEPS_SINGLE);
   end
endmodule : rat_unit

// ===== rat_unit_properties.sv
`timescale 1ns/1ps
module rat_unit_properties (
   // Clock and reset
   input logic               clk,
   input logic               rst,
   // Request
   input logic               req_valid,
   input logic               req_ready,
   input rat_pkg::rat_req_t  req,
   // Answer
   input logic               dst_we,
   input rat_pkg::rat_real_t dst,
   input rat_pkg::rat_stat_t stat,
   input logic               done,
   input logic [3:0]         prog_steps
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // =========================================
   // Operands of the request in flight
   rat_pkg::rat_op_t op_r;
   logic [31:0]      a_r;
   logic [31:0]      b_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_r <= rat_pkg::float_divide_op;
         a_r  <= 32'h00000000;
         b_r  <= 32'h00000000;
      end else if (req_valid && req_ready) begin
         op_r <= req.op;
         a_r  <= req.first_source_operand;
         b_r  <= req.second_source_operand;
      end
   end

   // =========================================
   // Properties
   property p_neg;
      dst_we && op_r == rat_pkg::float_negate_op |-> dst == {~a_r[31], a_r[30:0]};
   endproperty
   a_neg: assert property (p_neg) else $error("negate result wrong");
   property p_abs;
      dst_we && op_r == rat_pkg::float_magnitude_op |-> dst == {1'b0, a_r[30:0]};
   endproperty
   a_abs: assert property (p_abs) else $error("magnitude result wrong");
   property p_root_sign;
      dst_we && op_r == rat_pkg::float_root_op |-> !a_r[31] || a_r[30:0] == 31'h0;
   endproperty
   a_root_sign: assert property (p_root_sign) else $error("negative root written");
   property p_div_zero;
      dst_we && op_r == rat_pkg::float_divide_op |-> b_r[30:0] != 31'h0;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divisor written");
   property p_zero;
      dst_we && dst[30:0] == 31'h0 && op_r inside {rat_pkg::float_divide_op,
         rat_pkg::float_root_op, rat_pkg::trig_ordinate_op, rat_pkg::trig_abscissa_op}
         |-> ##[0:1] stat.zero_result_flag;
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag missing");
   property p_ovf;
      dst_we && op_r == rat_pkg::float_divide_op && a_r[30:23] != 8'h00 && b_r[30:0] != 31'h0
         && (10'({2'b00, a_r[30:23]} - {2'b00, b_r[30:23]} + 10'h07F) inside {[10'h100:10'h1FF]})
         |-> ##[0:1] stat.range_overflow_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag missing");
   property p_steps;
      done && op_r != rat_pkg::float_divide_op |-> prog_steps == 4'(rat_pkg::RAT_PROG_STEPS_SINGLE);
   endproperty
   a_steps: assert property (p_steps) else $error("step count wrong");
   property p_done;
      req_valid && req_ready |-> ##[1:200] done;
   endproperty
   a_done: assert property (p_done) else $error("no completion");
endmodule : rat_unit_properties

bind rat_unit rat_unit_properties rat_unit_properties_i (.clk(clk), .rst(rst),
   .req_valid(req_valid), .req_ready(req_ready), .req(req), .dst_we(dst_we), .dst(dst),
   .stat(stat), .done(done), .prog_steps(prog_steps));

// ===== rat_seq_model.sv
`timescale 1ns/1ps
module rat_seq_model (
   // Clock and reset
   input  logic               clk,
   input  logic               rst,
   // Command from the bench
   input  logic               cmd_go,
   input  rat_pkg::rat_op_t   cmd_op,
   input  logic [31:0]        cmd_a,
   input  logic [31:0]        cmd_b,
   input  logic [3:0]         cmd_lag,
   // Request to the unit
   output logic               req_valid,
   input  logic               req_ready,
   output rat_pkg::rat_req_t  req,
   // Answer from the unit
   input  logic               dst_we,
   input  rat_pkg::rat_real_t dst,
   input  rat_pkg::rat_stat_t stat,
   input  logic               done,
   input  logic [3:0]         prog_steps,
   // Results for the bench
   output logic               busy,
   output logic               got_we,
   output rat_pkg::rat_real_t got_dst,
   output rat_pkg::rat_stat_t got_stat,
   output logic [3:0]         got_steps
);
   logic [3:0]        lag_r;
   logic              sent_r;
   rat_pkg::rat_req_t hold_r;
   // Idle request lines invert every cycle, so stale operands show only on every other cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_valid <= 1'b0;
         req       <= '0;
         hold_r    <= '0;
         lag_r     <= 4'h0;
         sent_r    <= 1'b0;
         busy      <= 1'b0;
         got_we    <= 1'b0;
         got_dst   <= '0;
         got_stat  <= '0;
         got_steps <= 4'h0;
      end else begin
         if (cmd_go && !busy) begin
            busy   <= 1'b1;
            sent_r <= 1'b0;
            got_we <= 1'b0;
            lag_r  <= cmd_lag;
            hold_r <= {cmd_op, cmd_a, cmd_b};
            req    <= rat_pkg::rat_req_t'(~req);
         end else if (busy && !sent_r) begin
            if (lag_r != 4'h0) begin
               lag_r <= lag_r - 4'h1;
               req   <= rat_pkg::rat_req_t'(~req);
            end else if (!req_valid) begin
               req_valid <= 1'b1;
               req       <= hold_r;
            end else if (req_ready) begin
               req_valid <= 1'b0;
               sent_r    <= 1'b1;
               req       <= rat_pkg::rat_req_t'(~hold_r);
            end
         end else begin
            req <= rat_pkg::rat_req_t'(~req);
         end
         if (busy && dst_we) begin
            got_we  <= 1'b1;
            got_dst <= dst;
         end
         if (busy && sent_r && done) begin
            busy      <= 1'b0;
            got_stat  <= stat;
            got_steps <= prog_steps;
         end
      end
   end
endmodule : rat_seq_model

// ===== rat_unit_test.sv
`timescale 1ns/1ps
module rat_unit_test;
   localparam logic [3:0] STP_ONE = 4'(rat_pkg::RAT_PROG_STEPS_SINGLE);
   localparam logic [3:0] STP_TWO = 4'(rat_pkg::RAT_PROG_STEPS_DUAL);
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_go = 1'b0;
   rat_pkg::rat_op_t cmd_op = rat_pkg::float_divide_op;
   logic [31:0] cmd_a = 32'h00000000;
   logic [31:0] cmd_b = 32'h00000000;
   logic [3:0] cmd_lag = 4'h0;
   logic req_valid, req_ready, dst_we, done, busy, got_we;
   rat_pkg::rat_req_t req;
   rat_pkg::rat_real_t dst, got_dst;
   rat_pkg::rat_stat_t stat, got_stat;
   logic [3:0] prog_steps, got_steps;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   rat_unit rat_unit_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .dst_we(dst_we), .dst(dst), .stat(stat), .done(done),
      .prog_steps(prog_steps));
   rat_seq_model rat_seq_model_i (.clk(clk), .rst(rst), .cmd_go(cmd_go), .cmd_op(cmd_op),
      .cmd_a(cmd_a), .cmd_b(cmd_b), .cmd_lag(cmd_lag), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .dst_we(dst_we), .dst(dst), .stat(stat), .done(done),
      .prog_steps(prog_steps), .busy(busy), .got_we(got_we), .got_dst(got_dst),
      .got_stat(got_stat), .got_steps(got_steps));

   // =========================================
   // Shared tasks
   task automatic summarize();
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   function automatic logic near(input logic [31:0] s, input logic [31:0] e);
      return (s > e ? s - e : e - s) <= 32'h00000400;
   endfunction : near

   task automatic run(input rat_pkg::rat_op_t op, input logic [31:0] a, input logic [31:0] b,
                      input logic [3:0] lag);
      int n;
      @(posedge clk);
      cmd_op  <= op;
      cmd_a   <= a;
      cmd_b   <= b;
      cmd_lag <= lag;
      cmd_go  <= 1'b1;
      @(posedge clk);
      cmd_go <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (busy && n < 400);
      check(busy, 1'b0);
   endtask : run

   task automatic res(input logic w, input logic [31:0] d, input logic [3:0] s,
                      input logic [3:0] n);
      check(got_we, w);
      if (w) check(got_dst, d);
      check(got_stat, s);
      check(got_steps, n);
   endtask : res

   // =========================================
   // Scenarios
   task automatic t_divide();
      run(rat_pkg::float_divide_op, 32'h40C00000, 32'h40000000, 4'h0);
      res(1'b1, 32'h40400000, 4'h0, STP_TWO);
      run(rat_pkg::float_divide_op, 32'hC0C00000, 32'h40000000, 4'h5);
      res(1'b1, 32'hC0400000, 4'h0, STP_TWO);
      run(rat_pkg::float_divide_op, 32'h00000000, 32'h40000000, 4'h0);
      res(1'b1, 32'h00000000, 4'h8, STP_TWO);
      run(rat_pkg::float_divide_op, 32'h7F000000, 32'h3E800000, 4'h0);
      check(got_stat.range_overflow_flag, 1'b1);
      run(rat_pkg::float_divide_op, 32'h7F000000, 32'h3F800000, 4'h0);
      res(1'b1, 32'h7F000000, 4'h0, STP_TWO);
      run(rat_pkg::float_divide_op, 32'h40C00000, 32'h00000000, 4'h0);
      res(1'b0, 32'h00000000, 4'h2, STP_TWO);
   endtask : t_divide

   task automatic t_root();
      run(rat_pkg::float_root_op, 32'h40800000, 32'h00000000, 4'h0);
      res(1'b1, 32'h40000000, 4'h0, STP_ONE);
      run(rat_pkg::float_root_op, 32'h00000000, 32'h00000000, 4'h3);
      res(1'b1, 32'h00000000, 4'h8, STP_ONE);
      run(rat_pkg::float_root_op, 32'hC0800000, 32'h00000000, 4'h0);
      res(1'b0, 32'h00000000, 4'h1, STP_ONE);
   endtask : t_root

   task automatic t_sign();
      run(rat_pkg::float_magnitude_op, 32'hC0800000, 32'h00000000, 4'h0);
      res(1'b1, 32'h40800000, 4'h0, STP_ONE);
      run(rat_pkg::float_negate_op, 32'h40800000, 32'h00000000, 4'h0);
      res(1'b1, 32'hC0800000, 4'h0, STP_ONE);
   endtask : t_sign

   task automatic t_trig();
      run(rat_pkg::trig_ordinate_op, 32'h00000000, 32'h00000000, 4'h0);
      res(1'b1, 32'h00000000, 4'h8, STP_ONE);
      run(rat_pkg::trig_ordinate_op, rat_pkg::RAT_HALF_PI, 32'h00000000, 4'h2);
      check(near(got_dst, rat_pkg::RAT_ONE), 1'b1);
      run(rat_pkg::trig_abscissa_op, 32'h00000000, 32'h00000000, 4'h0);
      check(near(got_dst, rat_pkg::RAT_ONE), 1'b1);
      run(rat_pkg::trig_abscissa_op, rat_pkg::RAT_PI, 32'h00000000, 4'h0);
      check(near(got_dst, 32'hBF800000), 1'b1);
      check(got_steps, STP_ONE);
   endtask : t_trig

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_divide();
      t_root();
      t_sign();
      t_trig();
      summarize();
   end
endmodule : rat_unit_test
